// ===== i2cmc_master.sv
// Functional notes
// - setting master enable sends start, then address
// - arbitration loss clears enable, releases both lines
// - enable cleared by software zero or nak
// - stop after byte on nak or cleared enable, never after arbitration loss
// - direction bit follows the calling address
// - direction selects receive or transmit; reset clears
// - three bit rate select, reset zero
// - serial clock is cpu clock over divisor
// - divisor twenty doubling per code step
// - enable attempt while bus busy flags arbitration
// - missing acknowledge sets no acknowledge flag
// - busy set on start, cleared on stop
module i2cmc_master
	import i2cmc_pkg::*;
(
	input  wire logic          CLK_IN,
	input  wire logic          RST_IN,
	input  wire i2cmc_bus_type BUS_IN,
	output logic [7:0]         RDATA_OUT,
	input  wire logic          SCL_IN,
	output logic               SCL_OUT,
	output logic               SCL_OE_OUT,
	input  wire logic          SDA_IN,
	output logic               SDA_OUT,
	output logic               SDA_OE_OUT,
	output logic               IRQ_OUT
);
	logic [2:0]      scl_sync_reg, scl_sync_next;
	logic [2:0]      sda_sync_reg, sda_sync_next;
	logic            scl_f_reg, scl_f_next;
	logic            sda_f_reg, sda_f_next;
	logic            start_det;
	logic            stop_det;

	i2cmc_state_type state_reg, state_next;
	i2cmc_mctl_type  mctl_reg, mctl_next;
	logic [7:0]      addr_reg, addr_next;
	logic [7:0]      txd_reg, txd_next;
	logic [7:0]      rxd_reg, rxd_next;
	logic            tx_full_reg, tx_full_next;
	logic            rx_full_reg, rx_full_next;
	logic [2:0]      istat_reg, istat_next;
	logic [2:0]      imask_reg, imask_next;
	logic [7:0]      rdata_reg, rdata_next;
	logic            irq_reg, irq_next;
	logic [9:0]      qcnt_reg, qcnt_next;
	logic [1:0]      qph_reg, qph_next;
	logic [3:0]      bitcnt_reg, bitcnt_next;
	logic [7:0]      shift_reg, shift_next;
	logic            addr_ph_reg, addr_ph_next;
	logic            dir_reg, dir_next;
	logic            nak_seen_reg, nak_seen_next;
	logic            scl_oe_reg, scl_oe_next;
	logic            sda_oe_reg, sda_oe_next;
	logic            line_low_reg;

	logic [9:0]      qlen;
	logic            tick;
	logic            txing;
	logic            arb_lost;
	logic            nak_set;
	logic            byte_done;
	logic            wr_mctl;
	logic            busy_refuse;

	// input synchronisers and glitch filter
	always_comb begin
		scl_sync_next = {scl_sync_reg[1:0], SCL_IN};
		sda_sync_next = {sda_sync_reg[1:0], SDA_IN};
		scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
		sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
		start_det = scl_f_reg && scl_f_next && sda_f_reg && !sda_f_next;
		stop_det = scl_f_reg && scl_f_next && !sda_f_reg && sda_f_next;
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			scl_sync_reg <= RST_SYNC;
			sda_sync_reg <= RST_SYNC;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_f_reg <= scl_f_next;
			sda_f_reg <= sda_f_next;
		end
	end

	// bit engine, registers and line drive
	always_comb begin
		state_next = state_reg;
		mctl_next = mctl_reg;
		addr_next = addr_reg;
		txd_next = txd_reg;
		rxd_next = rxd_reg;
		tx_full_next = tx_full_reg;
		rx_full_next = rx_full_reg;
		imask_next = imask_reg;
		qcnt_next = 10'h000;
		qph_next = qph_reg;
		bitcnt_next = bitcnt_reg;
		shift_next = shift_reg;
		addr_ph_next = addr_ph_reg;
		dir_next = dir_reg;
		nak_seen_next = nak_seen_reg;
		arb_lost = 1'b0;
		nak_set = 1'b0;
		byte_done = 1'b0;
		wr_mctl = BUS_IN.wr && (BUS_IN.addr == OFS_MCTL);
		busy_refuse = wr_mctl && BUS_IN.wdata[BIT_MASTER_ENABLE] && !mctl_reg.master_enable && mctl_reg.bb;
		qlen = QUARTER_BASE << mctl_reg.rate;
		txing = addr_ph_reg || !dir_reg;
		tick = (state_reg != ST_IDLE) && (state_reg != ST_HOLD) && (qcnt_reg == qlen - 10'h001);

		if ((state_reg != ST_IDLE) && (state_reg != ST_HOLD) && !tick) begin
			qcnt_next = qcnt_reg + 10'h001;
		end
		if (tick) begin
			qph_next = qph_reg + 2'h1;
		end

		unique case (state_reg)
			ST_IDLE: begin
				qph_next = 2'h0;
				if (mctl_reg.master_enable) begin
					state_next = ST_START;
				end
			end
			ST_START: begin
				if (tick && qph_reg == 2'h3) begin
					state_next = ST_BIT;
					shift_next = {addr_reg[7:1], mctl_reg.master_direction};
					dir_next = mctl_reg.master_direction;
					addr_ph_next = 1'b1;
					bitcnt_next = 4'h0;
				end
			end
			ST_BIT: begin
				if (tick && qph_reg == 2'h2) begin
					if (bitcnt_reg == ACK_BIT) begin
						nak_seen_next = txing && sda_f_reg;
					end else if (txing && shift_reg[7] && !sda_f_reg) begin
						arb_lost = 1'b1;
					end else if (!txing) begin
						shift_next = {shift_reg[6:0], sda_f_reg};
					end
				end
				if (tick && qph_reg == 2'h3) begin
					if (bitcnt_reg == ACK_BIT) begin
						byte_done = 1'b1;
						addr_ph_next = 1'b0;
						if (!addr_ph_reg && dir_reg) begin
							rxd_next = shift_reg;
							rx_full_next = 1'b1;
						end
						if (nak_seen_reg) begin
							nak_set = 1'b1;
							state_next = ST_STOP;
						end else if (!mctl_reg.master_enable) begin
							state_next = ST_STOP;
						end else begin
							state_next = ST_HOLD;
						end
					end else begin
						bitcnt_next = bitcnt_reg + 4'h1;
						if (txing) begin
							shift_next = {shift_reg[6:0], 1'b0};
						end
					end
				end
				if (arb_lost) begin
					state_next = ST_IDLE;
				end
			end
			ST_HOLD: begin
				qph_next = 2'h0;
				bitcnt_next = 4'h0;
				if (!mctl_reg.master_enable) begin
					state_next = ST_STOP;
				end else if (dir_reg && !rx_full_reg) begin
					state_next = ST_BIT;
					shift_next = 8'h00;
				end else if (!dir_reg && tx_full_reg) begin
					state_next = ST_BIT;
					shift_next = txd_reg;
					tx_full_next = 1'b0;
				end
			end
			ST_STOP: begin
				if (tick && qph_reg == 2'h3) begin
					state_next = ST_IDLE;
				end
			end
		endcase

		if (BUS_IN.wr && BUS_IN.addr == OFS_ADDR) begin
			addr_next = BUS_IN.wdata;
		end
		if (BUS_IN.wr && BUS_IN.addr == OFS_TXD) begin
			txd_next = BUS_IN.wdata;
			tx_full_next = 1'b1;
		end
		if (BUS_IN.wr && BUS_IN.addr == OFS_IMASK) begin
			imask_next = BUS_IN.wdata[2:0];
		end
		if (BUS_IN.rd && BUS_IN.addr == OFS_RXD && !byte_done) begin
			rx_full_next = 1'b0;
		end

		if (wr_mctl) begin
			mctl_next.master_enable = BUS_IN.wdata[BIT_MASTER_ENABLE] && !busy_refuse;
			mctl_next.master_direction = BUS_IN.wdata[3];
			mctl_next.rate = BUS_IN.wdata[2:0];
			if (!BUS_IN.wdata[BIT_ARBITRATION_LOSS_FLAG]) begin
				mctl_next.arbitration_loss_flag = 1'b0;
			end
			if (!BUS_IN.wdata[BIT_NO_ACKNOWLEDGE_FLAG]) begin
				mctl_next.no_acknowledge_flag = 1'b0;
			end
		end
		if (arb_lost || busy_refuse) begin
			mctl_next.arbitration_loss_flag = 1'b1;
		end
		if (nak_set) begin
			mctl_next.no_acknowledge_flag = 1'b1;
		end
		if (arb_lost || nak_set) begin
			mctl_next.master_enable = 1'b0;
		end
		if (start_det) begin
			mctl_next.bb = 1'b1;
		end else if (stop_det) begin
			mctl_next.bb = 1'b0;
		end

		istat_next = (BUS_IN.rd && BUS_IN.addr == OFS_ISTAT) ? RST_IRQ : istat_reg;
		istat_next[IRQ_DONE] = istat_next[IRQ_DONE] | byte_done;
		istat_next[IRQ_AL] = istat_next[IRQ_AL] | arb_lost | busy_refuse;
		istat_next[IRQ_NAK] = istat_next[IRQ_NAK] | nak_set;
		irq_next = |(istat_next & imask_next);

		rdata_next = RST_DATA;
		if (BUS_IN.rd) begin
			unique case (BUS_IN.addr)
				OFS_MCTL:  rdata_next = mctl_reg;
				OFS_ADDR:  rdata_next = addr_reg;
				OFS_TXD:   rdata_next = txd_reg;
				OFS_RXD:   rdata_next = rxd_reg;
				OFS_ISTAT: rdata_next = {5'h00, istat_reg};
				OFS_IMASK: rdata_next = {5'h00, imask_reg};
				default:   rdata_next = RST_DATA;
			endcase
		end

		// line drive from the next state, so outputs line up with it
		scl_oe_next = 1'b0;
		sda_oe_next = 1'b0;
		unique case (state_next)
			ST_IDLE: begin
				scl_oe_next = 1'b0;
				sda_oe_next = 1'b0;
			end
			ST_START: begin
				sda_oe_next = qph_next[1];
				scl_oe_next = (qph_next == 2'h3);
			end
			ST_BIT: begin
				scl_oe_next = !qph_next[1];
				if (bitcnt_next == ACK_BIT) begin
					sda_oe_next = !addr_ph_next && dir_next;
				end else if (addr_ph_next || !dir_next) begin
					sda_oe_next = !shift_next[7];
				end
			end
			ST_HOLD: begin
				scl_oe_next = 1'b1;
			end
			ST_STOP: begin
				scl_oe_next = (qph_next == 2'h0);
				sda_oe_next = !qph_next[1];
			end
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_reg <= ST_IDLE;
			mctl_reg <= RST_MCTL;
			addr_reg <= RST_ADDR;
			txd_reg <= RST_DATA;
			rxd_reg <= RST_DATA;
			tx_full_reg <= 1'b0;
			rx_full_reg <= 1'b0;
			istat_reg <= RST_IRQ;
			imask_reg <= RST_IRQ;
			rdata_reg <= RST_DATA;
			irq_reg <= 1'b0;
			qcnt_reg <= 10'h000;
			qph_reg <= 2'h0;
			bitcnt_reg <= 4'h0;
			shift_reg <= RST_DATA;
			addr_ph_reg <= 1'b0;
			dir_reg <= 1'b0;
			nak_seen_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			line_low_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			mctl_reg <= mctl_next;
			addr_reg <= addr_next;
			txd_reg <= txd_next;
			rxd_reg <= rxd_next;
			tx_full_reg <= tx_full_next;
			rx_full_reg <= rx_full_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			qcnt_reg <= qcnt_next;
			qph_reg <= qph_next;
			bitcnt_reg <= bitcnt_next;
			shift_reg <= shift_next;
			addr_ph_reg <= addr_ph_next;
			dir_reg <= dir_next;
			nak_seen_reg <= nak_seen_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			line_low_reg <= 1'b0;
		end
	end

	assign RDATA_OUT = rdata_reg;
	assign SCL_OUT = line_low_reg;
	assign SDA_OUT = line_low_reg;
	assign SCL_OE_OUT = scl_oe_reg;
	assign SDA_OE_OUT = sda_oe_reg;
	assign IRQ_OUT = irq_reg;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	chk_arb_release: assert property (arb_lost |=> !SCL_OE_OUT && !SDA_OE_OUT && !mctl_reg.master_enable)
		else $error("lines or enable not released after arbitration loss");
	chk_nak_clear: assert property (nak_set |=> !mctl_reg.master_enable && mctl_reg.no_acknowledge_flag)
		else $error("enable not cleared by no acknowledge");
	chk_nak_stop: assert property (nak_set |=> state_reg == ST_STOP ##1 SCL_OE_OUT && SDA_OE_OUT)
		else $error("no stop after no acknowledge");
	chk_arb_nostop: assert property (arb_lost |=> state_reg == ST_IDLE [*2])
		else $error("stop driven after arbitration loss");
	chk_busy_refuse: assert property (busy_refuse |=> mctl_reg.arbitration_loss_flag && !mctl_reg.master_enable)
		else $error("enable taken while bus busy");
	chk_quarter_min: assert property (tick |=> !tick [*4])
		else $error("quarter bit shorter than base divisor");
	chk_rw_bit: assert property ((state_reg == ST_BIT && addr_ph_reg && bitcnt_reg == LAST_DATA)
		|-> SDA_OE_OUT == !dir_reg)
		else $error("direction bit not sent after address");
	chk_start_seq: assert property ((state_reg == ST_IDLE && mctl_reg.master_enable)
		|=> state_reg == ST_START && !SDA_OE_OUT && !SCL_OE_OUT)
		else $error("start sequence did not open with released lines");
	chk_nine_pulses: assert property (byte_done |-> bitcnt_reg == ACK_BIT && qph_reg == 2'h3)
		else $error("byte ended before nine clock pulses");
	chk_busy_track: assert property (start_det |=> mctl_reg.bb)
		else $error("busy flag not set on start");
	chk_busy_clear: assert property (stop_det && !start_det |=> !mctl_reg.bb)
		else $error("busy flag not cleared on stop");

	cov_byte_done: cover property (byte_done && !dir_reg);
	cov_rx_byte: cover property (byte_done && dir_reg && !addr_ph_reg);
	cov_arb_lost: cover property (arb_lost);
	cov_nak_stop: cover property (nak_set ##1 state_reg == ST_STOP);
endmodule

// ===== i2cmc_pkg.sv
package i2cmc_pkg;
	localparam logic [2:0] OFS_MCTL  = 3'h0;
	localparam logic [2:0] OFS_ADDR  = 3'h1;
	localparam logic [2:0] OFS_TXD   = 3'h2;
	localparam logic [2:0] OFS_RXD   = 3'h3;
	localparam logic [2:0] OFS_ISTAT = 3'h4;
	localparam logic [2:0] OFS_IMASK = 3'h5;

	localparam int BIT_ARBITRATION_LOSS_FLAG  = 7;
	localparam int BIT_NO_ACKNOWLEDGE_FLAG = 6;
	localparam int BIT_MASTER_ENABLE  = 4;

	localparam logic [7:0] RST_MCTL  = 8'h00;
	localparam logic [7:0] RST_ADDR  = 8'hA0;
	localparam logic [7:0] RST_DATA  = 8'h00;
	localparam logic [2:0] RST_IRQ   = 3'h0;
	localparam logic [2:0] RST_SYNC  = 3'h7;

	localparam int         DIV_BASE     = 20;
	localparam int         QUARTERS     = 4;
	localparam logic [9:0] QUARTER_BASE = 10'(DIV_BASE / QUARTERS);
	localparam logic [3:0] ACK_BIT      = 4'h8;
	localparam logic [3:0] LAST_DATA    = 4'h7;

	localparam int IRQ_DONE = 0;
	localparam int IRQ_AL   = 1;
	localparam int IRQ_NAK  = 2;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} i2cmc_bus_type;

	typedef struct packed {
		logic       arbitration_loss_flag;
		logic       no_acknowledge_flag;
		logic       bb;
		logic       master_enable;
		logic       master_direction;
		logic [2:0] rate;
	} i2cmc_mctl_type;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_STOP} i2cmc_state_type;
endpackage

// ===== i2cmc_slave.sv
module i2cmc_slave (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       nak_in,
	input  wire logic       clash_in,
	input  wire logic [7:0] tx_in,
	output logic            sda_oe_out,
	output logic [7:0]      byte_out,
	output int              pulses_out,
	output int              period_out,
	output int              stops_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_d, sda_d, rw, drv;
	logic [7:0] sh;
	int         bits, nbyte, cnt, nb;
	// clash pulls data low on command: a rival start or a lost arbitration
	assign sda_oe_out = drv | clash_in;
	always @(posedge clk_in) begin
		scl_d <= scl_in;
		sda_d <= sda_in;
		cnt   <= cnt + 1;
		nb    = (bits == 9) ? 0 : bits;
		if (rst_in) begin
			bits       <= 0;
			nbyte      <= 0;
			cnt        <= 0;
			drv        <= 1'b0;
			rw         <= 1'b0;
			pulses_out <= 0;
			stops_out  <= 0;
		end else if (scl_in && scl_d && sda_d && !sda_in) begin
			bits       <= 0;
			nbyte      <= 0;
			pulses_out <= 0;
		end else if (scl_in && scl_d && !sda_d && sda_in) begin
			stops_out  <= stops_out + 1;
		end else if (scl_in && !scl_d) begin
			pulses_out <= pulses_out + 1;
			period_out <= cnt;
			cnt        <= 1;
			sh         <= {sh[6:0], sda_in};
			bits       <= bits + 1;
		end else if (!scl_in && scl_d && bits == 8) begin
			byte_out   <= sh;
			rw         <= (nbyte == 0) ? sh[0] : rw;
			drv        <= !nak_in && !(rw && nbyte != 0);
		end else if (!scl_in && scl_d) begin
			drv        <= rw && (nbyte != 0 || bits == 9) && !tx_in[7 - nb];
			if (bits == 9) begin
				bits   <= 0;
				nbyte  <= nbyte + 1;
			end
		end
	end
endmodule

// ===== i2c_master_control_bench.sv
module i2c_master_control_bench
	import i2cmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	i2cmc_bus_type bus = '0;
	logic [7:0]    rdata, v, a;
	logic [7:0]    tx = 8'h80;
	logic          scl_oe, sda_oe, scl_o, sda_o, s_oe, irq, dir;
	logic          nak = 1'b0;
	logic          clash = 1'b0;
	logic [7:0]    s_byte;
	logic [31:0]   lfsr = 32'h7D9A;
	int            pulses, period, stops, s;
	int            fails = 0;
	int            n_compared = 0;
	int            cycles = 0;
	wire logic     scl_w = !(scl_oe && !scl_o);
	wire logic     sda_w = !((sda_oe && !sda_o) || s_oe);

	i2cmc_master DUT (.CLK_IN(clk), .RST_IN(rst), .BUS_IN(bus), .RDATA_OUT(rdata),
		.SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w),
		.SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .IRQ_OUT(irq));
	i2cmc_slave SLV (.clk_in(clk), .rst_in(rst), .scl_in(scl_w), .sda_in(sda_w),
		.nak_in(nak), .clash_in(clash), .tx_in(tx), .sda_oe_out(s_oe), .byte_out(s_byte),
		.pulses_out(pulses), .period_out(period), .stops_out(stops));

	always #4 clk = ~clk;

	function automatic logic [31:0] next_rand(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic print_verdict();
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		bus.addr  <= ad;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge clk);
		bus.wr    <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [2:0] ad);
		bus.addr <= ad;
		bus.rd   <= 1'b1;
		@(posedge clk);
		bus.rd   <= 1'b0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [2:0] ad, input logic [7:0] e, input string what);
		rd(ad);
		check(what, {8'h00, v}, {8'h00, e});
	endtask

	task automatic wait_irq();
		do @(negedge clk); while (irq !== 1'b1);
		@(posedge clk);
	endtask

	task automatic wait_stop();
		do @(negedge clk); while (stops == s);
		repeat (8) @(posedge clk);
	endtask

	task automatic free_bus();
		clash <= 1'b0;
		repeat (8) @(posedge clk);
		rchk(OFS_MCTL, 8'h80, "freed");
		rd(OFS_ISTAT);
		check("lost event", {8'h00, v & 8'h02}, 16'h0002);
		wr(OFS_MCTL, 8'h00);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(OFS_MCTL, 8'h00, "mctl reset");
		rchk(OFS_ADDR, 8'hA0, "addr reset");
		rchk(3'h6, 8'h00, "unmapped");
		wr(OFS_IMASK, 8'h07);
		for (int r = 0; r < 8; r++) begin
			lfsr = next_rand(lfsr);
			a = lfsr[7:0];
			dir = (r < 6) && r[0];
			tx <= {1'b1, lfsr[14:8]};
			wr(OFS_ADDR, a);
			wr(OFS_MCTL, {4'h1, dir, 3'(r)});
			wait_irq();
			check("pulses", 16'(pulses), 16'h0009);
			check("period", 16'(period), 16'h0014 << r);
			check("address byte", {8'h00, s_byte}, {8'h00, a[7:1], dir});
			rchk(OFS_ISTAT, 8'h01, "done");
			if (dir) begin
				wait_irq();
				rchk(OFS_ISTAT, 8'h01, "done");
			end
			s = stops;
			wr(OFS_MCTL, {5'h00, dir, 3'(r)});
			wait_stop();
			if (dir) begin
				rchk(OFS_RXD, tx, "rx data");
			end
			rchk(OFS_MCTL, {5'h00, dir, 3'(r)}, "after stop");
		end
		nak <= 1'b1;
		wr(OFS_IMASK, 8'h00);
		s = stops;
		wr(OFS_MCTL, 8'h10);
		wait_stop();
		rchk(OFS_MCTL, 8'h40, "nak stop");
		check("masked irq", {15'h0000, irq}, 16'h0000);
		wr(OFS_IMASK, 8'h04);
		@(negedge clk);
		check("irq", {15'h0000, irq}, 16'h0001);
		@(posedge clk);
		rd(OFS_ISTAT);
		check("nak event", {8'h00, v & 8'h04}, 16'h0004);
		@(negedge clk);
		check("irq clear", {15'h0000, irq}, 16'h0000);
		@(posedge clk);
		nak <= 1'b0;
		wr(OFS_MCTL, 8'h00);
		wr(OFS_IMASK, 8'h07);
		clash <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(OFS_MCTL, 8'h20, "busy");
		wr(OFS_MCTL, 8'h10);
		rchk(OFS_MCTL, 8'hA0, "refused");
		free_bus();
		wr(OFS_ADDR, 8'hA0);
		s = stops;
		wr(OFS_MCTL, 8'h10);
		clash <= 1'b1;
		repeat (60) @(posedge clk);
		check("lines", {14'h0000, scl_oe, sda_oe}, 16'h0000);
		check("line levels", {14'h0000, scl_o, sda_o}, 16'h0000);
		check("no stop", 16'(stops), 16'(s));
		rchk(OFS_MCTL, 8'hA0, "lost");
		free_bus();
		print_verdict();
	end
endmodule
